// [hdl/skl_pkg.sv]
// What this block does
// - Key column data is taken only while that row's common line is driven low.
// - The active key row common line moves to the next row every 11.68 ms.
// - Lamp column data is driven so a lamp lights only while its row common is high.
// - Four lamp row commons are stepped in turn, each lit 1.46 ms in every 5.84 ms.
// - Group station numbers follow three rotary switches and track any change.
// - Switches 0, 1, 2 give X/Y 00-1F, 20-3F and 40-5F to the three groups.
// - The card takes three link stations out of at most eight on the link.
// - Contact chatter up to 3 ms on a direct input is never misread.
// - A direct input change is reported no sooner than 3 ms and no later than 16 ms.
// - Eight key row commons, eight key column inputs, lamp commons and lamp data in two groups.
package skl_pkg;
    localparam int CLK_HZ = 50_000_000;
    // Times in microseconds
    localparam int KEY_ROW_US = 11_680;
    localparam int LAMP_ROW_US = 1_460;
    localparam int DEB_US = 4_000;
    localparam int KEY_ROW_CYC = KEY_ROW_US * (CLK_HZ / 1_000_000);
    localparam int LAMP_ROW_CYC = LAMP_ROW_US * (CLK_HZ / 1_000_000);
    localparam int DEB_CYC = DEB_US * (CLK_HZ / 1_000_000);
    localparam int KEY_ROWS = 8;
    localparam int LAMP_ROWS = 4;
    localparam int STATIONS = 3;
    localparam int MAX_STATIONS = 8;
    localparam int FREE_STATIONS = MAX_STATIONS - STATIONS;
    localparam logic [3:0] STD_FIRST_SCAN_GROUP_SELECTOR = 4'h0;
    localparam logic [3:0] STD_SECOND_SCAN_GROUP_SELECTOR = 4'h1;
    localparam logic [3:0] STD_DIO = 4'h2;
    localparam logic [7:0] KEY_IDLE = 8'hFF;
    localparam logic [3:0] LAMP_IDLE = 4'h0;
endpackage : skl_pkg

// [hdl/skl_scan_io.sv]
`timescale 1ns/100ps
module skl_scan_io #(
    parameter int KEY_ROW_CYC = skl_pkg::KEY_ROW_CYC,
    parameter int LAMP_ROW_CYC = skl_pkg::LAMP_ROW_CYC,
    parameter int DEB_CYC = skl_pkg::DEB_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] first_scan_group_selector,
    input wire logic [3:0] second_scan_group_selector,
    input wire logic [3:0] direct_io_group_selector,
    input wire logic [7:0] key_column_data_n,
    input wire logic [31:0] directIn,
    input wire logic [63:0] lampData,
    output logic [7:0] key_row_common_n,
    output logic [3:0] lamp_row_common_a,
    output logic [3:0] lamp_row_common_b,
    output logic [7:0] lamp_column_data_a_n,
    output logic [7:0] lamp_column_data_b_n,
    output logic [63:0] keyState,
    output logic [31:0] directState,
    output logic [3:0] scanOneStation,
    output logic [3:0] scanTwoStation,
    output logic [3:0] directStation
);
    // ************************
    // Input synchronisers
    // ************************
    logic [7:0] keyS1_r, keyS2_r;
    logic [31:0] dinS1_r, dinS2_r;
    logic [11:0] swS1_r, swS2_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            keyS1_r <= 8'hFF;
            keyS2_r <= 8'hFF;
            dinS1_r <= 32'h0;
            dinS2_r <= 32'h0;
            // Standard settings, so the stations keep their reset value through the sync
            swS1_r <= {skl_pkg::STD_DIO, skl_pkg::STD_SECOND_SCAN_GROUP_SELECTOR, skl_pkg::STD_FIRST_SCAN_GROUP_SELECTOR};
            swS2_r <= {skl_pkg::STD_DIO, skl_pkg::STD_SECOND_SCAN_GROUP_SELECTOR, skl_pkg::STD_FIRST_SCAN_GROUP_SELECTOR};
        end else begin
            keyS1_r <= key_column_data_n;
            keyS2_r <= keyS1_r;
            dinS1_r <= directIn;
            dinS2_r <= dinS1_r;
            swS1_r <= {direct_io_group_selector, second_scan_group_selector,
                first_scan_group_selector};
            swS2_r <= swS1_r;
        end
    end

    // ************************
    // Key row scan
    // ************************
    logic [19:0] keyCnt_r, keyCnt_nxt;
    logic [2:0] keyRow_r, keyRow_nxt;
    logic [7:0] keyCom_r, keyCom_nxt;
    logic [63:0] keyState_r, keyState_nxt;
    // Sample at the end of each row slot so the column lines have settled
    always_comb begin
        keyCnt_nxt = keyCnt_r + 20'h1;
        keyRow_nxt = keyRow_r;
        keyState_nxt = keyState_r;
        if (keyCnt_r == 20'(KEY_ROW_CYC - 1)) begin
            keyCnt_nxt = 20'h0;
            keyRow_nxt = keyRow_r + 3'h1;
            if (!keyCom_r[keyRow_r]) begin
                keyState_nxt[keyRow_r*8 +: 8] = ~keyS2_r;
            end
        end
        keyCom_nxt = ~(8'h01 << keyRow_nxt);
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            keyCnt_r <= 20'h0;
            keyRow_r <= 3'h0;
            keyCom_r <= skl_pkg::KEY_IDLE;
            keyState_r <= 64'h0;
        end else begin
            keyCnt_r <= keyCnt_nxt;
            keyRow_r <= keyRow_nxt;
            keyCom_r <= keyCom_nxt;
            keyState_r <= keyState_nxt;
        end
    end
    assign key_row_common_n = keyCom_r;
    assign keyState = keyState_r;

    // ************************
    // Lamp row scan
    // ************************
    logic [16:0] lampCnt_r, lampCnt_nxt;
    logic [1:0] lampRow_r, lampRow_nxt;
    logic [3:0] lampCom_r, lampCom_nxt;
    logic [15:0] lampDat_r, lampDat_nxt;
    // Data and common change on the same edge so no lamp ghosts a neighbour row
    always_comb begin
        lampCnt_nxt = lampCnt_r + 17'h1;
        lampRow_nxt = lampRow_r;
        if (lampCnt_r == 17'(LAMP_ROW_CYC - 1)) begin
            lampCnt_nxt = 17'h0;
            lampRow_nxt = lampRow_r + 2'h1;
        end
        lampCom_nxt = 4'h1 << lampRow_nxt;
        lampDat_nxt = {~lampData[32 + lampRow_nxt*8 +: 8], ~lampData[lampRow_nxt*8 +: 8]};
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lampCnt_r <= 17'h0;
            lampRow_r <= 2'h0;
            lampCom_r <= skl_pkg::LAMP_IDLE;
            lampDat_r <= 16'hFFFF;
        end else begin
            lampCnt_r <= lampCnt_nxt;
            lampRow_r <= lampRow_nxt;
            lampCom_r <= lampCom_nxt;
            lampDat_r <= lampDat_nxt;
        end
    end
    assign lamp_row_common_a = lampCom_r;
    assign lamp_row_common_b = lampCom_r;
    assign lamp_column_data_a_n = lampDat_r[7:0];
    assign lamp_column_data_b_n = lampDat_r[15:8];

    // ************************
    // Direct input debounce
    // ************************
    // 4 ms of steady level: longer than 3 ms chatter, well under 16 ms
    logic [31:0] dinState_r, dinState_nxt;
    logic [17:0] debCnt_r [32];
    logic [17:0] debCnt_nxt [32];
    logic [31:0] debDone;
    always_comb begin
        dinState_nxt = dinState_r;
        for (int i = 0; i < 32; i++) begin
            debCnt_nxt[i] = 18'h0;
            debDone[i] = (debCnt_r[i] == 18'(DEB_CYC - 1));
            if (dinS2_r[i] != dinState_r[i]) begin
                debCnt_nxt[i] = debCnt_r[i] + 18'h1;
                if (debDone[i]) begin
                    dinState_nxt[i] = dinS2_r[i];
                    debCnt_nxt[i] = 18'h0;
                end
            end
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dinState_r <= 32'h0;
            for (int i = 0; i < 32; i++) begin
                debCnt_r[i] <= 18'h0;
            end
        end else begin
            dinState_r <= dinState_nxt;
            debCnt_r <= debCnt_nxt;
        end
    end
    assign directState = dinState_r;

    // ************************
    // Station assignment
    // ************************
    // three link stations
    logic [skl_pkg::STATIONS*4-1:0] station_r, station_nxt;
    always_comb begin
        station_nxt = swS2_r;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            station_r <= {skl_pkg::STD_DIO, skl_pkg::STD_SECOND_SCAN_GROUP_SELECTOR, skl_pkg::STD_FIRST_SCAN_GROUP_SELECTOR};
        end else begin
            station_r <= station_nxt;
        end
    end
    assign scanOneStation = station_r[3:0];
    assign scanTwoStation = station_r[7:4];
    assign directStation = station_r[11:8];

    // ************************
    // Checks
    // ************************
    // one key row low, except the idle edge right after reset
    one_key_row_a: assert property (@(posedge clock) disable iff (!rst_n)
        $countones(~key_row_common_n) == 1 || !$past(rst_n))
        else $error("key rows not one hot");
    one_lamp_row_a: assert property (@(posedge clock) disable iff (!rst_n)
        $countones(lamp_row_common_a) == 1 || !$past(rst_n))
        else $error("lamp rows not one hot");
    key_row_step_a: assert property (@(posedge clock) disable iff (!rst_n)
        (keyCnt_r == 20'(KEY_ROW_CYC - 1)) |=> keyRow_r == $past(keyRow_r) + 3'h1)
        else $error("key row did not advance");
    lamp_row_step_a: assert property (@(posedge clock) disable iff (!rst_n)
        (lampCnt_r == 17'(LAMP_ROW_CYC - 1)) |=> lampRow_r == $past(lampRow_r) + 2'h1)
        else $error("lamp row did not advance");
    key_sample_a: assert property (@(posedge clock) disable iff (!rst_n)
        $changed(keyState_r) |-> $past(keyCnt_r) == 20'(KEY_ROW_CYC - 1))
        else $error("key sampled outside slot end");
    // data for active row, common and data from the same edge
    lamp_data_a: assert property (@(posedge clock) disable iff (!rst_n)
        !$past(rst_n) || (lamp_row_common_a == (4'h1 << lampRow_r)
            && lamp_column_data_a_n == ~8'($past(lampData) >> (lampRow_r * 8))
            && lamp_column_data_b_n == ~8'($past(lampData) >> (32 + lampRow_r * 8))))
        else $error("lamp data not for active row");
    din_settle_a: assert property (@(posedge clock) disable iff (!rst_n)
        ((dinState_r ^ $past(dinState_r)) & ~$past(debDone)) == 32'h0)
        else $error("direct input reported early");
    station_track_a: assert property (@(posedge clock) disable iff (!rst_n)
        station_r == $past(swS2_r))
        else $error("station does not follow switch");
endmodule : skl_scan_io

// [bench/skl_matrix_model.sv]
`timescale 1ns/100ps
// ****************************************
// Key switch matrix and lamp array
// ****************************************
module skl_matrix_model (
    input wire logic clock,
    input wire logic [7:0] key_row_common_n,
    input wire logic [3:0] lamp_row_common_a,
    input wire logic [3:0] lamp_row_common_b,
    input wire logic [7:0] lamp_column_data_a_n,
    input wire logic [7:0] lamp_column_data_b_n,
    input wire logic [63:0] keyPressed,
    output logic [7:0] key_column_data_n,
    output logic [63:0] litImage
);
    // diode matrix, pull-ups hold columns high when no row is low
    always_comb begin
        key_column_data_n = 8'hFF;
        for (int r = 0; r < 8; r++) begin
            if (key_row_common_n[r] === 1'b0) key_column_data_n &= ~keyPressed[r*8+:8];
        end
    end
    // a lamp shows only while its row common is high
    always @(posedge clock) begin
        for (int r = 0; r < 4; r++) begin
            if (lamp_row_common_a[r] === 1'b1) begin
                litImage[r*8+:8] <= ~lamp_column_data_a_n;
            end
            if (lamp_row_common_b[r] === 1'b1) begin
                litImage[32+r*8+:8] <= ~lamp_column_data_b_n;
            end
        end
    end
endmodule : skl_matrix_model

// [bench/tb_skl_scan_io.sv]
`timescale 1ns/100ps
// ****************************************
// Scan and direct I/O bench
// ****************************************
module tb_skl_scan_io;
    // Short counts: 1 ms is scaled to MS cycles
    localparam int KR = 8;
    localparam int LR = 4;
    localparam int DB = 16;
    localparam int MS = DB / 4;
    logic clock, rstN, monOn;
    logic [3:0] sw1, sw2, swD, lcA, lcB, prevL, st1, st2, stD;
    logic [7:0] colN, rowN, ldA, ldB, prevK;
    logic [31:0] dIn, dState;
    logic [63:0] lamps, keys, kState, lit;
    int nMismatch = 0, numChecks = 0, kChg = 0, lChg = 0;
    skl_scan_io #(.KEY_ROW_CYC(KR), .LAMP_ROW_CYC(LR), .DEB_CYC(DB)) i_dut (
        .clock(clock), .rst_n(rstN), .first_scan_group_selector(sw1),
        .second_scan_group_selector(sw2), .direct_io_group_selector(swD),
        .key_column_data_n(colN), .directIn(dIn), .lampData(lamps),
        .key_row_common_n(rowN), .lamp_row_common_a(lcA), .lamp_row_common_b(lcB),
        .lamp_column_data_a_n(ldA), .lamp_column_data_b_n(ldB), .keyState(kState),
        .directState(dState), .scanOneStation(st1), .scanTwoStation(st2), .directStation(stD));
    skl_matrix_model i_far (.clock(clock), .key_row_common_n(rowN),
        .lamp_row_common_a(lcA), .lamp_row_common_b(lcB),
        .lamp_column_data_a_n(ldA), .lamp_column_data_b_n(ldB), .keyPressed(keys),
        .key_column_data_n(colN), .litImage(lit));
    task automatic chk(input logic ok, input string msg);
        numChecks++;
        if (ok !== 1'b1) begin
            nMismatch++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask : tick
    // Watch the row commons on the falling edge, away from updates
    always @(negedge clock) begin
        if (monOn) begin
            // one row active, lamp groups share commons
            chk($countones(~rowN) === 1, "key row overlap");
            chk($countones(lcA) === 1 && lcA === lcB, "lamp row overlap");
            if (rowN !== prevK) kChg++;
            if (lcA !== prevL) lChg++;
            if (rowN !== prevK) chk(rowN === {prevK[6:0], prevK[7]}, "key row order");
            if (lcA !== prevL) chk(lcA === {prevL[2:0], prevL[3]}, "lamp row order");
        end
        prevK <= rowN;
        prevL <= lcA;
    end
    task automatic resetCheck();
        monOn = 0;
        rstN = 0;
        tick(3);
        chk({rowN, lcA, lcB, ldA, ldB} === 32'hFF00_FFFF, "reset rows");
        chk(kState === 64'h0 && dState === 32'h0, "reset image");
        chk({st1, st2, stD} === 12'h012, "reset stations");
        rstN = 1;
        tick(4);
        monOn = 1;
    endtask : resetCheck
    task automatic stations();
        tick(4);
        chk({st1, st2, stD} === 12'h012, "standard stations");
        {sw1, sw2, swD} = 12'h5A3;
        tick(4);
        chk({st1, st2, stD} === 12'h5A3, "stations follow");
    endtask : stations
    // Whole window: 16 key row steps, 32 lamp row steps
    task automatic rowTiming();
        kChg = 0;
        lChg = 0;
        tick(16 * KR);
        chk(kChg === 16 && lChg === 32, "row period");
    endtask : rowTiming
    task automatic keyScan();
        // keys held for two full scans
        keys = 64'h8001_4002_2004_1008;
        tick(16 * KR + 2);
        chk(kState === keys, "key image");
        keys = 64'h0;
        tick(16 * KR + 2);
        chk(kState === 64'h0, "key release");
    endtask : keyScan
    task automatic lampScan();
        lamps = 64'hA5C3_0F81_3C96_E718;
        tick(8 * LR + 2);
        chk(lit === lamps, "lamp image");
    endtask : lampScan
    task automatic debounce();
        int t;
        int e;
        // a spike as long as the tolerated chatter is ignored
        dIn = 32'h0000_0001;
        tick(3 * MS);
        dIn = 32'h0;
        for (t = 0; t < 20 * MS && dState === 32'h0; t++) tick(1);
        chk(t === 20 * MS, "chatter seen");
        for (e = 0; e < 2; e++) begin
            // each level held past 40 ms
            dIn = e[0] ? 32'h0 : 32'h8000_0000;
            for (t = 0; t < 20 * MS && dState[31] === e[0]; t++) tick(1);
            chk(t >= 3 * MS && t <= 16 * MS, "input delay");
            tick(40 * MS);
        end
    endtask : debounce
    task automatic results();
        if (nMismatch == 0 && numChecks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    // Free-running clock
    initial begin
        clock = 0;
        forever #10 clock = ~clock;
    end
    // Main sequence, second reset in mid-run
    initial begin
        {sw1, sw2, swD} = {skl_pkg::STD_FIRST_SCAN_GROUP_SELECTOR, skl_pkg::STD_SECOND_SCAN_GROUP_SELECTOR, skl_pkg::STD_DIO};
        {dIn, keys, lamps, monOn, rstN} = '0;
        resetCheck();
        stations();
        rowTiming();
        keyScan();
        lampScan();
        debounce();
        resetCheck();
        rowTiming();
        results();
    end
    // Watchdog well past the planned run length
    initial begin
        repeat (5000) @(posedge clock);
        nMismatch++;
        results();
    end
endmodule : tb_skl_scan_io
